/* core/bpst_bin.sv */
// free-running sampler gathering min and max power per bin
`timescale 1ns/100ps
`default_nettype none
module bpst_bin
    import bpst_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire bpst_pkg::bpst_power_t power,
    output logic strobe,
    output logic bin_done,
    output bpst_pkg::bpst_bin_s bin
);
    typedef struct packed {
        logic [3:0] div;
        logic [9:0] cnt;
        bpst_bin_s run;
        bpst_bin_s out;
        logic done;
        logic stb;
    } bpst_bin_state_s;

    bpst_bin_state_s s_q;
    bpst_bin_state_s s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        // never gated by triggers: sampling runs free
        s_d.stb = (s_q.div == SAMPLE_LAST); // RULE1
        s_d.div = s_d.stb ? 4'h0 : s_q.div + 4'h1; // RULE1
        if (s_q.stb)
        begin
            if (s_q.cnt == 10'h000)
            begin
                s_d.run.max = power; // RULE17
                s_d.run.min = power; // RULE17
            end
            else
            begin
                if (power > s_q.run.max)
                    s_d.run.max = power; // RULE2
                if (power < s_q.run.min)
                    s_d.run.min = power; // RULE2
            end
            if (s_q.cnt == BIN_LAST)
            begin
                s_d.cnt = 10'h000;
                s_d.done = 1'b1; // RULE2
                s_d.out = s_d.run;
            end
            else
                s_d.cnt = s_q.cnt + 10'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign strobe = s_q.stb;
    assign bin_done = s_q.done;
    assign bin = s_q.out;

    property p_rate;
        @(posedge clk) disable iff (reset)
        s_q.stb |=> (!s_q.stb)[*8] ##1 !s_q.stb ##1 s_q.stb;
    endproperty
    a_rate: assert property (p_rate) // RULE1
        else $error("sample strobe not every ten clocks");

    property p_clear;
        @(posedge clk) disable iff (reset)
        (s_q.stb && s_q.cnt == 10'h000) |=>
            (s_q.run.max == $past(power) && s_q.run.min == $past(power));
    endproperty
    a_clear: assert property (p_clear) // RULE17
        else $error("bin extremes not restarted at first sample");

    property p_bin_len;
        @(posedge clk) disable iff (reset)
        s_q.done |-> (s_q.cnt == 10'h000 && $past(s_q.cnt) == BIN_LAST);
    endproperty
    a_bin_len: assert property (p_bin_len) // RULE2
        else $error("bin closed at wrong sample count");
endmodule
`default_nettype wire

/* core/bpst_frame_trig.sv */
// per-frame trigger at a programmed slot and bit position
`timescale 1ns/100ps
`default_nettype none
module bpst_frame_trig
    import bpst_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire bpst_pkg::bpst_fpos_s pos,
    input wire logic frame_start,
    input wire logic qbit_tick,
    output logic frame_trig
);
    typedef struct packed {
        logic [12:0] qcount;
        logic fire;
    } bpst_ft_state_s;

    bpst_ft_state_s s_q;
    bpst_ft_state_s s_d;
    logic [12:0] target;

    // nominal 156.25-bit slots: exact 625 quarter bits per slot, so no slot
    // fires early; each trigger lands on its nominal quarter bit
    always_comb
    begin
        target = 13'(pos.slot * QB_PER_SLOT) // RULE12
            + 13'({pos.trigger_bit_offset, 2'b00}); // RULE10
    end

    always_comb
    begin
        s_d = s_q;
        s_d.fire = 1'b0;
        if (frame_start)
            s_d.qcount = 13'h0000; // RULE10
        else if (qbit_tick)
        begin
            s_d.qcount = s_q.qcount + 13'h0001;
            s_d.fire = enable && (s_q.qcount == target); // RULE8
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign frame_trig = s_q.fire;

    property p_fire;
        @(posedge clk) disable iff (reset)
        (enable && qbit_tick && !frame_start && s_q.qcount == target)
            |=> frame_trig;
    endproperty
    a_fire: assert property (p_fire) // RULE8
        else $error("frame trigger missed its position");

    property p_no_stray;
        @(posedge clk) disable iff (reset)
        frame_trig |-> $past(enable) && $past(s_q.qcount) == $past(target);
    endproperty
    a_no_stray: assert property (p_no_stray) // RULE12
        else $error("frame trigger at wrong position");
endmodule
`default_nettype wire

/* core/bpst_top.sv */
// peak burst power measurement with frame and delayed trigger outputs
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1 - sample detected power continuously at 10 MHz, never paused
// RULE2 - 75 us bins of 750 samples keep their max and min
// RULE3 - on a burst trigger save the next six completed bins
// RULE4 - first saved bin starts up to one bin after the trigger
// RULE5 - the first saved bin is dropped from the result
// RULE6 - results below the qualification level are discarded
// RULE7 - report the average of bins one to five
// RULE8 - frame trigger enabled fires once every frame until cleared
// RULE9 - frame position: slot digit at most 7, bit offset at most 9C
// RULE10 - position counts from bit zero of slot zero, downlink timing
// RULE11 - user allows 4.7 bit modulator delay and rounds to whole bits
// RULE12 - frame trigger early by 0, .75, .5, .25 bit per slot pair; the code fires at the nominal 625 quarter-bit slot position
// RULE13 - burst trigger waits programmed delay, then measures and toggles
// RULE14 - delayed trigger output toggles only when a measurement starts
// RULE15 - overpower in pulse mode sets bit 5 of hardware status one
// RULE16 - in envelope-rise mode the delay runs from the rising edge
// RULE17 - bin max and min restart at the start of every bin
// RULE18 - triggers during a six-bin capture are ignored
module bpst_top
    import bpst_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire bpst_pkg::bpst_power_t power_in,
    input wire logic burst_trig,
    input wire logic rf_rise_trig,
    input wire logic frame_start,
    input wire logic qbit_tick,
    output logic frame_trig_out,
    output logic meas_trig_out
);
    typedef struct packed {
        bpst_state_e state;
        logic [19:0] dly_cnt;
        logic [2:0] bin_idx;
        logic [18:0] sum;
        bpst_power_t result;
        logic result_valid;
        logic [7:0] discard_cnt;
        logic meas_trig;
        logic [2:0] ctrl;
        bpst_fpos_s fpos;
        logic [19:0] trig_delay;
        bpst_power_t qual;
        bpst_power_t expect_lvl;
        logic overpower;
        logic waitreq;
        logic [31:0] rdata;
    } bpst_top_state_s;

    bpst_top_state_s s_q;
    bpst_top_state_s s_d;
    logic strobe;
    logic bin_done;
    bpst_bin_s bin;
    logic trig;
    logic [39:0] product;
    bpst_power_t avg;
    logic acc_taken;
    logic [31:0] wmask;
    logic [31:0] wval;

    // ------------------------------------------------------------
    // sampler and frame trigger
    // ------------------------------------------------------------
    bpst_bin u_bin (
        .clk(clk),
        .reset(reset),
        .power(power_in),
        .strobe(strobe),
        .bin_done(bin_done),
        .bin(bin)
    );

    bpst_frame_trig u_frame (
        .clk(clk),
        .reset(reset),
        .enable(s_q.ctrl[CTRL_FTRIG_EN]),
        .pos(s_q.fpos),
        .frame_start(frame_start),
        .qbit_tick(qbit_tick),
        .frame_trig(frame_trig_out)
    );

    // ------------------------------------------------------------
    // measurement sequence
    // ------------------------------------------------------------
    always_comb
    begin
        trig = s_q.ctrl[CTRL_RF_RISE] ? rf_rise_trig : burst_trig; // RULE16
        product = 40'(s_q.sum) * 40'(DIV5_MUL);
        avg = 16'(product >> DIV5_SHIFT); // RULE7
        acc_taken = !s_q.waitreq && (avs_read || avs_write);
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wval = '0;
        unique case (avs_address)
            REG_CTRL: wval = 32'(s_q.ctrl);
            REG_FRAME_POS: wval = 32'(s_q.fpos);
            REG_TRIG_DELAY: wval = 32'(s_q.trig_delay);
            REG_QUAL_LEVEL: wval = 32'(s_q.qual);
            REG_EXPECT_LEVEL: wval = 32'(s_q.expect_lvl);
            default: wval = '0;
        endcase
        wval = (wval & ~wmask) | (avs_writedata & wmask);
    end

    always_comb
    begin
        s_d = s_q;
        unique case (s_q.state)
            ST_IDLE:
            begin
                if (trig)
                begin
                    s_d.state = ST_DELAY; // RULE13
                    s_d.dly_cnt = 20'h00000;
                end
            end
            ST_DELAY:
            begin
                // triggers here are ignored as well
                if (s_q.dly_cnt == s_q.trig_delay)
                begin
                    s_d.state = ST_ALIGN; // RULE13
                    s_d.meas_trig = !s_q.meas_trig; // RULE14
                end
                else
                    s_d.dly_cnt = s_q.dly_cnt + 20'h00001;
            end
            ST_ALIGN:
            begin
                // the partial bin running at start is skipped
                if (bin_done)
                begin
                    s_d.state = ST_CAPTURE; // RULE4
                    s_d.bin_idx = 3'h0;
                    s_d.sum = '0;
                end
            end
            ST_CAPTURE:
            begin
                if (bin_done)
                begin
                    if (s_q.bin_idx != BIN_DROPPED)
                        s_d.sum = s_q.sum + 19'(bin.max); // RULE5
                    if (s_q.bin_idx == CAP_LAST)
                        s_d.state = ST_DONE; // RULE3
                    else
                        s_d.bin_idx = s_q.bin_idx + 3'h1; // RULE18
                end
            end
            ST_DONE:
            begin
                s_d.state = ST_IDLE;
                if (avg < s_q.qual)
                    s_d.discard_cnt = s_q.discard_cnt + 8'h01; // RULE6
                else
                begin
                    s_d.result = avg; // RULE7
                    s_d.result_valid = 1'b1;
                end
            end
            default: s_d.state = ST_IDLE;
        endcase

        // ------------------------------------------------------------
        // register bus: one wait state, answer at the following edge
        // ------------------------------------------------------------
        s_d.waitreq = !((avs_read || avs_write) && s_q.waitreq);
        s_d.rdata = '0;
        if ((avs_read || avs_write) && s_q.waitreq)
        begin
            unique case (avs_address)
                REG_CTRL: s_d.rdata = 32'(s_q.ctrl);
                REG_FRAME_POS: s_d.rdata = 32'(s_q.fpos);
                REG_TRIG_DELAY: s_d.rdata = 32'(s_q.trig_delay);
                REG_QUAL_LEVEL: s_d.rdata = 32'(s_q.qual);
                REG_RESULT: s_d.rdata = {s_q.result_valid, 15'h0000,
                                         s_q.result};
                REG_HW_STATUS1: s_d.rdata = 32'(s_q.overpower)
                                            << HW1_OVERPOWER;
                REG_EXPECT_LEVEL: s_d.rdata = 32'(s_q.expect_lvl);
                REG_STATUS: s_d.rdata = {21'h000000, s_q.discard_cnt,
                                         s_q.state};
                default: s_d.rdata = '0;
            endcase
        end
        if (acc_taken && avs_write)
        begin
            unique case (avs_address)
                REG_CTRL: s_d.ctrl = wval[2:0]; // RULE8
                // limits are the writer's duty; out-of-range slots
                // simply never match within a frame
                REG_FRAME_POS: s_d.fpos = wval[10:0]; // RULE9
                REG_TRIG_DELAY: s_d.trig_delay = wval[19:0];
                REG_QUAL_LEVEL: s_d.qual = wval[15:0];
                REG_EXPECT_LEVEL: s_d.expect_lvl = wval[15:0];
                REG_HW_STATUS1:
                    if (avs_writedata[HW1_OVERPOWER]
                        && avs_byteenable[0])
                        s_d.overpower = 1'b0;
                default: s_d.overpower = s_d.overpower;
            endcase
        end
        // a result landing with the clearing read keeps its flag: set wins
        else if (acc_taken && avs_address == REG_RESULT
                 && !(s_q.state == ST_DONE && avg >= s_q.qual))
            s_d.result_valid = 1'b0;
        // set after clear so a coincident event wins
        if (s_q.ctrl[CTRL_PULSE] && strobe && s_q.state == ST_CAPTURE
            && power_in > s_q.expect_lvl)
            s_d.overpower = 1'b1; // RULE15
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.ctrl <= CTRL_RESET;
            s_q.trig_delay <= TRIG_DELAY_RESET;
            s_q.qual <= QUAL_RESET;
            s_q.expect_lvl <= EXPECT_RESET;
            s_q.waitreq <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign meas_trig_out = s_q.meas_trig;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_toggle_start;
        @(posedge clk) disable iff (reset)
        (s_q.state == ST_DELAY && s_q.dly_cnt == s_q.trig_delay)
            |=> (meas_trig_out != $past(meas_trig_out))
                && s_q.state == ST_ALIGN;
    endproperty
    a_toggle_start: assert property (p_toggle_start) // RULE13
        else $error("measurement start did not toggle the output");

    property p_toggle_only;
        @(posedge clk) disable iff (reset)
        (meas_trig_out != $past(meas_trig_out)) |-> s_q.state == ST_ALIGN;
    endproperty
    a_toggle_only: assert property (p_toggle_only) // RULE14
        else $error("delayed trigger toggled outside measurement start");

    property p_ignore;
        @(posedge clk) disable iff (reset)
        (s_q.state == ST_CAPTURE && trig && !bin_done)
            |=> s_q.state == ST_CAPTURE && $stable(s_q.bin_idx);
    endproperty
    a_ignore: assert property (p_ignore) // RULE18
        else $error("trigger disturbed a running capture");

    property p_drop_first;
        @(posedge clk) disable iff (reset)
        (s_q.state == ST_CAPTURE && bin_done && s_q.bin_idx == BIN_DROPPED)
            |=> s_q.sum == 19'h00000;
    endproperty
    a_drop_first: assert property (p_drop_first) // RULE5
        else $error("first bin entered the sum");

    property p_qual;
        @(posedge clk) disable iff (reset)
        (s_q.state == ST_DONE && avg < s_q.qual)
            |=> $stable(s_q.result) && s_q.state == ST_IDLE;
    endproperty
    a_qual: assert property (p_qual) // RULE6
        else $error("unqualified result was reported");

    property p_average;
        @(posedge clk) disable iff (reset)
        (s_q.state == ST_DONE && avg >= s_q.qual)
            |=> s_q.result == 16'($past(s_q.sum) / 19'h00005)
                && s_q.result_valid;
    endproperty
    a_average: assert property (p_average) // RULE7
        else $error("result is not the five-bin average");

    property p_overpower;
        @(posedge clk) disable iff (reset)
        (s_q.ctrl[CTRL_PULSE] && strobe && s_q.state == ST_CAPTURE
            && power_in > s_q.expect_lvl) |=> s_q.overpower;
    endproperty
    a_overpower: assert property (p_overpower) // RULE15
        else $error("overpower flag not set");

    property p_six_bins;
        @(posedge clk) disable iff (reset)
        (s_q.state == ST_CAPTURE && bin_done && s_q.bin_idx == CAP_LAST)
            |=> s_q.state == ST_DONE;
    endproperty
    a_six_bins: assert property (p_six_bins) // RULE3
        else $error("capture did not end after six bins");
endmodule
`default_nettype wire

/* inc/bpst_pkg.sv */
// shared constants and types of the burst power sampler and trigger block
package bpst_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SAMPLE_NS = 100;
    localparam int SAMPLE_CYC = CLK_MHZ * SAMPLE_NS / 1000;
    localparam int BIN_US = 75;
    localparam int BIN_SAMPLES = BIN_US * 1000 / SAMPLE_NS;
    localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYC - 1);
    localparam logic [9:0] BIN_LAST = 10'(BIN_SAMPLES - 1);
    localparam logic [2:0] CAP_LAST = 3'h5;
    localparam logic [2:0] BIN_DROPPED = 3'h0;
    // divide by five as multiply and shift, exact below 2**22
    localparam logic [19:0] DIV5_MUL = 20'hCCCCD;
    localparam int DIV5_SHIFT = 22;
    // frame trigger counted in quarter bits, 156.25 bits per slot
    localparam logic [12:0] QB_PER_SLOT = 13'h271;
    localparam int QB_BIT_SHIFT = 2;
    localparam logic [2:0] SLOT_MAX = 3'h7;
    localparam logic [7:0] BIT_OFFSET_MAX = 8'h9C;
    // ------------------------------------------------------------
    // registers (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_FRAME_POS = 5'h04;
    localparam logic [4:0] REG_TRIG_DELAY = 5'h08;
    localparam logic [4:0] REG_QUAL_LEVEL = 5'h0C;
    localparam logic [4:0] REG_RESULT = 5'h10;
    localparam logic [4:0] REG_HW_STATUS1 = 5'h14;
    localparam logic [4:0] REG_EXPECT_LEVEL = 5'h18;
    localparam logic [4:0] REG_STATUS = 5'h1C;
    localparam int CTRL_FTRIG_EN = 0;
    localparam int CTRL_RF_RISE = 1;
    localparam int CTRL_PULSE = 2;
    localparam int HW1_OVERPOWER = 5;
    localparam int RESULT_VALID = 31;
    localparam int FPOS_SLOT_LSB = 8;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [19:0] TRIG_DELAY_RESET = 20'h00000;
    localparam logic [15:0] QUAL_RESET = 16'h0000;
    localparam logic [15:0] EXPECT_RESET = 16'hFFFF;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [15:0] bpst_power_t;
    typedef struct packed {
        bpst_power_t max;
        bpst_power_t min;
    } bpst_bin_s;
    typedef struct packed {
        logic [2:0] slot;
        logic [7:0] trigger_bit_offset;
    } bpst_fpos_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DELAY = 3'b001,
        ST_ALIGN = 3'b010,
        ST_CAPTURE = 3'b011,
        ST_DONE = 3'b100
    } bpst_state_e;
endpackage

/* testbench/bpst_instr_model.sv */
// external instrument that counts trigger pulses and transitions
`timescale 1ns/100ps
`default_nettype none
module bpst_instr_model
(
    input wire logic clk,
    input wire logic reset,
    input wire logic frame_trig,
    input wire logic meas_trig,
    output int n_frame,
    output int n_meas
);
    logic meas_last_q;
    // edge-sensitive input: any transition is one trigger
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            n_frame <= 0;
            n_meas <= 0;
            meas_last_q <= 1'b0;
        end
        else
        begin
            // takes the position as given, no modulator delay correction
            if (frame_trig === 1'b1) n_frame <= n_frame + 1;
            if (meas_trig !== meas_last_q) n_meas <= n_meas + 1;
            meas_last_q <= meas_trig;
        end
    end
endmodule
`default_nettype wire

/* testbench/bpst_top_tb.sv */
// self-checking bench of the burst power sampler and trigger block
`timescale 1ns/100ps
`default_nettype none
module bpst_top_tb;
    import bpst_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    bpst_power_t power_in = 16'h1234;
    logic burst_trig = 1'b0;
    logic rf_rise_trig = 1'b0;
    logic frame_start = 1'b0;
    logic qbit_tick = 1'b0;
    logic frame_trig_out;
    logic meas_trig_out;
    int n_frame;
    int n_meas;
    int fail_count = 0;
    int n_checks = 0;
    logic [31:0] rd;
    always #5 clk = ~clk;
    bpst_top u_dut (
        .clk(clk),
        .reset(reset),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .power_in(power_in),
        .burst_trig(burst_trig),
        .rf_rise_trig(rf_rise_trig),
        .frame_start(frame_start),
        .qbit_tick(qbit_tick),
        .frame_trig_out(frame_trig_out),
        .meas_trig_out(meas_trig_out)
    );
    bpst_instr_model u_instr (
        .clk(clk),
        .reset(reset),
        .frame_trig(frame_trig_out),
        .meas_trig(meas_trig_out),
        .n_frame(n_frame),
        .n_meas(n_meas)
    );
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic pulse_trig(input logic rise);
        @(posedge clk);
        if (rise) rf_rise_trig <= 1'b1;
        else burst_trig <= 1'b1;
        @(posedge clk);
        rf_rise_trig <= 1'b0;
        burst_trig <= 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 8; i++)
            rdchk(5'(i * 4), (i == 6) ? 32'h0000FFFF : 32'h0);
        bus(1'b1, 5'h01, 32'hFFFFFFFF);
        rdchk(5'h01, 32'h0);
    endtask
    // slot 1, offset 2: nominal 625 quarter bits per slot, so fires at 633
    task automatic t_frame(input logic en, input int exp_n);
        int base;
        int at;
        at = -1;
        bus(1'b1, REG_FRAME_POS, 32'h00000102);
        bus(1'b1, REG_CTRL, {31'h0, en});
        base = n_frame;
        @(posedge clk);
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        for (int k = 0; k < 700; k++)
        begin
            qbit_tick <= 1'b1;
            @(posedge clk);
            qbit_tick <= 1'b0;
            @(negedge clk);
            if (frame_trig_out === 1'b1) at = k;
            @(posedge clk);
        end
        @(negedge clk);
        chk(32'(n_frame - base), 32'(exp_n));
        if (en) chk(32'(at), 32'd633);
    endtask
    // trigger, time the output transition, retrigger while busy;
    // a loud first captured bin must not reach the average
    task automatic t_meas(input logic rise, input logic [19:0] dly);
        logic old;
        int n;
        int base;
        bus(1'b1, REG_TRIG_DELAY, {12'h0, dly});
        base = n_meas;
        old = meas_trig_out;
        power_in <= 16'h7FFF;
        pulse_trig(rise);
        n = 1;
        @(negedge clk);
        while (meas_trig_out === old && n < 3000)
        begin
            @(posedge clk);
            n++;
            @(negedge clk);
        end
        chk(32'(n), 32'(dly) + 32'd2);
        pulse_trig(rise);
        do
            bus(1'b0, REG_STATUS, 32'h0);
        while (rd[2:0] !== 3'h3);
        // retrigger inside the six-bin capture itself
        pulse_trig(rise);
        repeat (100) @(posedge clk);
        power_in <= 16'h1234;
        do
            bus(1'b0, REG_STATUS, 32'h0);
        while (rd[2:0] !== 3'h0);
        @(negedge clk);
        chk(32'(n_meas - base), 32'd1);
    endtask
    initial
    begin
        #1500000;
        fail_count++;
        tally_and_finish;
    end
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_frame(1'b1, 1);
        t_frame(1'b0, 0);
        t_meas(1'b0, 20'h00005);
        rdchk(REG_RESULT, 32'h80001234);
        rdchk(REG_RESULT, 32'h00001234);
        rdchk(REG_HW_STATUS1, 32'h0);
        bus(1'b1, REG_QUAL_LEVEL, 32'h00002000);
        bus(1'b1, REG_EXPECT_LEVEL, 32'h00001000);
        bus(1'b1, REG_CTRL, 32'h00000006);
        t_meas(1'b1, 20'h00000);
        rdchk(REG_RESULT, 32'h00001234);
        rdchk(REG_STATUS, 32'h00000008);
        rdchk(REG_HW_STATUS1, 32'h00000020);
        bus(1'b1, REG_HW_STATUS1, 32'h00000020);
        rdchk(REG_HW_STATUS1, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
